// file: bench/aipd_bank_asserts.sv
// port checker for the record bank
// assumes binding to every bank instance
`timescale 1ns/100ps
module aipd_bank_asserts
#(
  parameter NCH = 8
)
(
  // clock and reset
  input wire               mclk,
  input wire               nrst,
  input wire               clk_en,
  // answers and status
  input wire               rsp_valid,
  input wire               rsp_err,
  input wire               rsp_last,
  input wire               stat_fail,
  input wire               mod_err_led,
  // results
  input wire [NCH*16-1:0]  chan_value,
  input wire [NCH*2-1:0]   interference_rejection,
  input wire [NCH-1:0]     chan_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  function in_lim(input [NCH*16-1:0] v);
    integer k;
    begin
      in_lim = 1'b1;
      for (k = 0; k < NCH; k = k + 1)
        if ($signed(v[16*k+:16]) > $signed(16'h7EFF) ||
            $signed(v[16*k+:16]) < $signed(16'h8100))
          in_lim = 1'b0;
    end
  endfunction

  a_flag_valid: assert property ((rsp_last || rsp_err) |-> rsp_valid)
    else $error("answer flag without valid");
  a_last_single: assert property (rsp_last && clk_en |=> !rsp_last)
    else $error("last byte flag held");
  a_stream_gap: assert property (rsp_valid && !rsp_last && !rsp_err && clk_en
    |=> rsp_valid)
    else $error("gap inside record stream");
  a_value_clamp: assert property (in_lim(chan_value))
    else $error("channel value beyond limits");
  a_rej_write: assert property ($changed(interference_rejection)
    |-> $past(rsp_valid) && !$past(rsp_err))
    else $error("rejection changed without write");
  a_enable_write: assert property ($changed(chan_enable)
    |-> $past(rsp_valid) && !$past(rsp_err))
    else $error("enable changed without write");
  a_fail_led: assert property ((stat_fail && clk_en)[*4] |-> mod_err_led)
    else $error("module fault not shown on led");
  a_freeze_hold: assert property (!clk_en |=> $stable(chan_value) && $stable(rsp_valid))
    else $error("state moved while frozen");

  c_full_record: cover property (rsp_last && !rsp_err);
  c_refused: cover property (rsp_err);
  c_frozen: cover property (!clk_en);
endmodule // aipd_bank_asserts

bind aipd_bank aipd_bank_asserts #(.NCH(NCH)) aipd_bank_asserts_i
(
  .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .rsp_valid(rsp_valid),
  .rsp_err(rsp_err), .rsp_last(rsp_last), .stat_fail(stat_fail),
  .mod_err_led(mod_err_led), .chan_value(chan_value),
  .interference_rejection(interference_rejection), .chan_enable(chan_enable)
);

// file: bench/aipd_bank_bench.sv
// self-checking bench for the record bank
// assumes the coupler model drives the request port
`timescale 1ns/100ps
module aipd_bank_bench;
  reg          mclk;
  reg          nrst;
  reg          clk_en;
  reg  [4:0]   stat;
  reg  [95:0]  sample;
  reg          sample_stb;
  wire         req_valid, req_write, rsp_valid, rsp_err, rsp_last, mod_err_led;
  wire [1:0]   req_mode;
  wire [15:0]  req_addr, interference_rejection;
  wire [7:0]   req_sub, req_wdata, rsp_rdata, chan_enable, chan_err_led;
  wire [4:0]   req_byte;
  wire [127:0] chan_value;
  reg  [127:0] ev;
  reg  [15:0]  w;
  reg  [7:0]   fn;
  integer      err_count, samples_checked, i, k, t, seed;

  always #12.5 mclk = ~mclk;

  aipd_bank aipd_bank_i
  (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid),
    .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr),
    .req_sub(req_sub), .req_byte(req_byte), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .rsp_last(rsp_last), .stat_fail(stat[0]), .stat_int(stat[1]),
    .stat_ext(stat[2]), .stat_aux_missing(stat[3]), .stat_comm_err(stat[4]),
    .sample(sample), .sample_stb(sample_stb), .chan_value(chan_value),
    .interference_rejection(interference_rejection), .chan_enable(chan_enable),
    .chan_err_led(chan_err_led), .mod_err_led(mod_err_led)
  );

  aipd_host_model aipd_host_model_i
  (
    .mclk(mclk), .req_valid(req_valid), .req_write(req_write),
    .req_mode(req_mode), .req_addr(req_addr), .req_sub(req_sub),
    .req_byte(req_byte), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .rsp_last(rsp_last)
  );

  task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task rd(input [1:0] m, input [15:0] a, input [7:0] s);
    aipd_host_model_i.xfer(1'b0, m, a, s, 5'h00, 8'h00);
  endtask

  task wr(input [15:0] a, input [4:0] b, input [7:0] d);
    aipd_host_model_i.xfer(1'b1, 2'd0, a, 8'h00, b, d);
  endtask

  // expected diag byte while no fault is pending
  function [7:0] dx(input integer n);
    case (n)
      1: dx = 8'h15;
      4: dx = 8'h71;
      5, 6: dx = 8'h08;
      default: dx = 8'h00;
    endcase
  endfunction

  function [15:0] exp_val(input [7:0] f, input [11:0] raw);
    integer v, hi, lo;
    begin
      hi = f[5] ? 20480 : 32511;
      lo = f[1] ? (f[5] ? -20480 : -32512) : (f[5] ? -3277 : -4864);
      v = $signed(raw) * (f[5] ? 16384 : 27648) / 2047;
      if (v > hi)
        v = hi;
      if (v < lo)
        v = lo;
      exp_val = v[15:0];
    end
  endfunction

  initial
  begin
    #(25 * 10000);
    err_count = err_count + 1;
    print_verdict;
  end

  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    stat = 5'h00;
    sample = 96'h0;
    sample_stb = 1'b0;
    err_count = 0;
    samples_checked = 0;
    seed = $urandom(32'hCD63BCA5);
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      k = (i == 4) ? 16'h007F : (i[1] ? 16'h2F01 : 16'h0001) - i[0];
      rd({1'b0, i[1]}, k[15:0], 8'h00);
      check("rec len", aipd_host_model_i.rd_n, i == 4 ? 1 : (i[0] ? 4 : 20));
      check("rec err", aipd_host_model_i.rd_err, i == 4);
      for (t = 0; t < aipd_host_model_i.rd_n; t = t + 1)
        check("rec byte", aipd_host_model_i.rd_q[t], dx(t));
    end
    for (k = 0; k < 18; k = k + 1)
    begin
      rd(2'd2, 16'h5005, 8'h02 + k[7:0]);
      check("sub len", aipd_host_model_i.rd_n, k == 17 ? 4 : 1);
      check("sub err", aipd_host_model_i.rd_err, k == 16);
      check("sub byte", aipd_host_model_i.rd_q[0], k < 16 ? dx(k) : 0);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      for (k = 0; k < 8; k = k + 1)
        w[2*k+:2] = $urandom % 3;
      if (i == 3)
        w = 16'hC000;
      wr(16'h0001, 5'h00, w[7:0]);
      wr(16'h0001, 5'h01, w[15:8]);
      check("rejection", interference_rejection, w);
      rd(2'd2, 16'h5005, 8'h02);
      check("parm flag", aipd_host_model_i.rd_q[0][7], i == 3);
    end
    wr(16'h0001, 5'h00, 8'h00);
    wr(16'h0001, 5'h01, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      fn = i[1] ? (i[0] ? 8'h12 : 8'h22) : (i[0] ? 8'h20 : 8'h10);
      for (k = 0; k < 8; k = k + 1)
      begin
        case (k % 3)
          0: wr(16'h0080 + k, 5'h00, fn);
          1: aipd_host_model_i.xfer(1'b1, 2'd1, 16'h3102 + k, 8'h00, 5'h00, fn);
          default: aipd_host_model_i.xfer(1'b1, 2'd2, 16'h3100, 8'h02 + k, 5'h00, fn);
        endcase
        check("wr err", aipd_host_model_i.rd_err, 0);
        sample[12*k+:12] = (k < 2) ? 12'h7FF + k : $urandom;
      end
      for (k = 0; k < 8; k = k + 1)
        ev[16*k+:16] = exp_val(fn, sample[12*k+:12]);
      sample_stb = 1'b1;
      @(posedge mclk);
      #1 sample_stb = 1'b0;
      for (k = 0; k < 8; k = k + 1)
        check("value", chan_value[16*k+:16], ev[16*k+:16]);
      check("enable", chan_enable, 8'hFF);
      if (!fn[1])
      begin
        rd(2'd2, 16'h5005, 8'h0B);
        check("under flag", aipd_host_model_i.rd_q[0][6], 1'b1);
        rd(2'd2, 16'h5005, 8'h09);
        check("summary", aipd_host_model_i.rd_q[0][1], 1'b1);
        check("chan led", chan_err_led[1], 1'b1);
      end
    end
    wr(16'h0085, 5'h00, 8'hFF);
    check("disable", chan_enable, 8'hDF);
    wr(16'h0002, 5'h00, 8'h00);
    check("wr err", aipd_host_model_i.rd_err, 1);
    wr(16'h0085, 5'h00, 8'h12);
    sample = 96'h0;
    sample_stb = 1'b1;
    @(posedge mclk);
    #1 sample_stb = 1'b0;
    repeat (8) @(posedge mclk);
    for (i = 0; i < 5; i = i + 1)
    begin
      stat = 5'h01 << i;
      repeat (4) @(posedge mclk);
      rd(2'd2, 16'h5005, i == 4 ? 8'h05 : 8'h02);
      check("status", aipd_host_model_i.rd_q[0], i < 3 ? 1 << i : 8'h10);
      check("mod led", mod_err_led, i < 4);
    end
    stat = 5'h00;
    rd(2'd2, 16'h5005, 8'h13);
    check("stamp", aipd_host_model_i.rd_q[0] != 0 || aipd_host_model_i.rd_q[1] != 0, 1);
    // freeze and a second reset exercise the hold and restart paths
    clk_en = 1'b0;
    sample = {8{12'h7FF}};
    sample_stb = 1'b1;
    repeat (6) @(posedge mclk);
    check("frozen", |chan_value, 0);
    #1 clk_en = 1'b1;
    sample_stb = 1'b0;
    nrst = 1'b0;
    repeat (2) @(posedge mclk);
    check("rst rej", interference_rejection, 16'h0000);
    check("rst en", chan_enable, 8'hFF);
    #1 nrst = 1'b1;
    rd(2'd0, 16'h0000, 8'h00);
    check("rst diag", aipd_host_model_i.rd_q[0], 8'h00);
    print_verdict;
  end
endmodule // aipd_bank_bench

// file: bench/aipd_host_model.sv
// coupler model: issues record requests, gathers answer bytes
// assumes one request at a time, answers as the bank hands over
`timescale 1ns/100ps
module aipd_host_model
(
  // clock
  input  wire        mclk,
  // request side
  output reg         req_valid,
  output reg         req_write,
  output reg  [1:0]  req_mode,
  output reg  [15:0] req_addr,
  output reg  [7:0]  req_sub,
  output reg  [4:0]  req_byte,
  output reg  [7:0]  req_wdata,
  // answer side
  input  wire        rsp_valid,
  input  wire [7:0]  rsp_rdata,
  input  wire        rsp_err,
  input  wire        rsp_last
);
  reg     [7:0] rd_q [0:39];
  integer       rd_n;
  reg           rd_err;

  initial
  begin
    {req_valid, req_write, req_mode, req_addr, req_sub, req_byte, req_wdata} = 0;
  end

  task xfer(input w, input [1:0] m, input [15:0] a, input [7:0] s,
            input [4:0] b, input [7:0] d);
    integer t;
    begin
      rd_n = 0;
      rd_err = 1'b0;
      @(posedge mclk);
      #1;
      {req_valid, req_write, req_mode, req_addr, req_sub, req_byte, req_wdata}
        = {1'b1, w, m, a, s, b, d};
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      // released lines must not keep looking valid
      {req_addr, req_sub, req_wdata} = ~{req_addr, req_sub, req_wdata};
      // a write answers at the taking edge, so look before waiting
      for (t = 0; t < 40; t = t + 1)
      begin
        if (rsp_valid === 1'b1)
        begin
          rd_q[rd_n] = rsp_rdata;
          rd_n = rd_n + 1;
          rd_err = rd_err | rsp_err;
          if (rsp_last === 1'b1)
            t = 40;
        end
        if (t < 40)
        begin
          @(posedge mclk);
          #1;
        end
      end
      // one idle cycle before the next request
      @(posedge mclk);
      #1;
    end
  endtask
endmodule // aipd_host_model

// file: hw/aipd_bank.v
// parameter and diagnostic record bank of an eight-channel voltage input
// assumes the backplane coupler sends one byte per strobe on a record port
//
// Overview of operation
// R1: suppression word, two bits per channel
// R2: codes: off, 60 Hz, 50 Hz; 11 undefined
// R3: function byte FFh disables the channel
// R4: decimal format: 10 V is 27648
// R5: power-of-two format: 10 V is 16384
// R6: function 12h clamps to 7EFFh / 8100h
// R7: function 22h clamps to 5000h / B000h
// R8: unipolar floors ED00h and F333h
// R9: errors light channel indicator and diag record
// R10: no diagnostic interrupt, read only
// R11: record 01h full diag, 00h four bytes
// R12: index 2F01h full diag, 2F00h four bytes
// R13: index 5005h subindex 02h..13h per field; subindex 12h is refused
// R14: constant description bytes 15h,71h,08h,08h
// R15: first diag byte module error flags
// R16: channel byte: config, underflow, overflow bits
// R17: summary bit n for channel n
// R18: microsecond ticker from zero, wraps at 2^32
// R19: function bytes default to 12h
// R20: outputs clamped two's complement words
`timescale 1ns/100ps
`include "aipd_regs.vh"
module aipd_bank
#(
  parameter NCH = 8
)
(
  // clock and reset
  input  wire              mclk,
  input  wire              nrst,
  input  wire              clk_en,
  // request port: mode 0 record set, 1 index, 2 index plus subindex
  input  wire              req_valid,
  input  wire              req_write,
  input  wire [1:0]        req_mode,
  input  wire [15:0]       req_addr,
  input  wire [7:0]        req_sub,
  input  wire [4:0]        req_byte,
  input  wire [7:0]        req_wdata,
  // answer port
  output reg               rsp_valid,
  output reg  [7:0]        rsp_rdata,
  output reg               rsp_err,
  output reg               rsp_last,
  // module status inputs
  input  wire              stat_fail,
  input  wire              stat_int,
  input  wire              stat_ext,
  input  wire              stat_aux_missing,
  input  wire              stat_comm_err,
  // converter samples, twelve bits per channel
  input  wire [NCH*12-1:0] sample,
  input  wire              sample_stb,
  // results
  output reg  [NCH*16-1:0] chan_value,
  output reg  [NCH*2-1:0]  interference_rejection,
  output reg  [NCH-1:0]    chan_enable,
  output reg  [NCH-1:0]    chan_err_led,
  output reg               mod_err_led
);
  localparam [5:0] TICK_DIV = `AIPD_CLK_MHZ * `AIPD_TICK_US;

  // request decoder states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RD   = 3'b010;
  localparam [2:0] ST_WR   = 3'b100;

  // parameter store, diag record bytes and the microsecond ticker
  reg [15:0]      mains_rejection_select_r;
  reg [NCH*8-1:0] channel_range_select_r;
  reg [7:0]       module_diag_flags_r;
  reg [7:0]       secondary_diag_flags_r;
  reg [7:0]       channel_error_summary_r;
  reg [NCH*8-1:0] channel_error_detail_r;
  reg [31:0]      diag_event_timestamp_r;
  reg [31:0]      usec_r;
  reg [5:0]       div_r;
  reg [2:0]       state_r;
  reg [4:0]       rd_byte_r;
  reg [4:0]       rd_len_r;
  reg             rd_bad_r;

  // live channel results, decoded each cycle from the stored setup
  wire [NCH*16-1:0] cvalue;
  wire [NCH*8-1:0]  cerr;
  wire [NCH-1:0]    cany;
  wire [NCH-1:0]    sup_bad;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      aipd_chan u_chan
      (
        .fn_num (channel_range_select_r[g*8 +: 8]),
        .raw    (sample[g*12 +: 12]),
        .value  (cvalue[g*16 +: 16]),
        .err    (cerr[g*8 +: 8])
      );
      // code 11 is undefined and treated as a parameter error
      assign sup_bad[g] = (mains_rejection_select_r[g*2 +: 2] == 2'b11); // [R2]
      assign cany[g]    = (|cerr[g*8 +: 8]) | sup_bad[g];
    end
  endgenerate

  // diagnostic record byte at a given position
  function [7:0] diag_byte;
    input [4:0] pos;
    begin
      case (pos)
        5'd0:    diag_byte = module_diag_flags_r; // [R15]
        5'd1:    diag_byte = `AIPD_MODCLASS; // [R14]
        5'd2:    diag_byte = 8'h00;
        5'd3:    diag_byte = secondary_diag_flags_r;
        5'd4:    diag_byte = `AIPD_CHKIND; // [R14]
        5'd5:    diag_byte = `AIPD_DIAG_BITS_PER_CHANNEL; // [R14]
        5'd6:    diag_byte = `AIPD_CHANNEL_COUNT; // [R14]
        5'd7:    diag_byte = channel_error_summary_r; // [R17]
        5'd16:   diag_byte = diag_event_timestamp_r[7:0];
        5'd17:   diag_byte = diag_event_timestamp_r[15:8];
        5'd18:   diag_byte = diag_event_timestamp_r[23:16];
        5'd19:   diag_byte = diag_event_timestamp_r[31:24];
        default: diag_byte = (pos >= 5'd8 && pos <= 5'd15)
                             ? channel_error_detail_r[(pos - 5'd8) * 8 +: 8] : 8'h00;
      endcase
    end
  endfunction

  // decode a request into a diag start byte and length; write targets too
  reg [4:0] dec_start;
  reg [4:0] dec_len;
  reg       dec_diag;
  reg       dec_mains_rejection_select;
  reg       dec_fn;
  reg [2:0] dec_ch;
  always @*
  begin
    dec_start = 5'd0;
    dec_len   = 5'd0;
    dec_diag  = 1'b0;
    dec_mains_rejection_select  = 1'b0;
    dec_fn    = 1'b0;
    dec_ch    = 3'd0;
    case (req_mode)
      2'd0:
      begin
        if (!req_write && req_addr[7:0] == `AIPD_REC_DIAG_FULL)
        begin
          dec_diag = 1'b1;
          dec_len  = `AIPD_DIAG_LEN; // [R11]
        end
        else if (!req_write && req_addr[7:0] == `AIPD_REC_DIAG_SHORT)
        begin
          dec_diag = 1'b1;
          dec_len  = `AIPD_DIAG_SHORT_LEN; // [R11]
        end
        else if (req_write && req_addr[7:0] == `AIPD_REC_PARAM_MAINS_REJECTION_SELECT)
          dec_mains_rejection_select = 1'b1;
        else if (req_write
                 && (req_addr[7:0] & 8'hF8) == `AIPD_REC_PARAM_FN0)
        begin
          dec_fn = 1'b1; // [R19]
          dec_ch = req_addr[2:0];
        end
      end
      2'd1:
      begin
        if (!req_write && req_addr == `AIPD_IX_DIAG_FULL)
        begin
          dec_diag = 1'b1;
          dec_len  = `AIPD_DIAG_LEN; // [R12]
        end
        else if (!req_write && req_addr == `AIPD_IX_DIAG_SHORT)
        begin
          dec_diag = 1'b1;
          dec_len  = `AIPD_DIAG_SHORT_LEN; // [R12]
        end
        else if (req_write && (req_addr == `AIPD_IX_PARAM_SUPR0
                            || req_addr == `AIPD_IX_PARAM_SUPR1))
          dec_mains_rejection_select = 1'b1;
        else if (req_write && req_addr >= `AIPD_IX_PARAM_FN0
                           && req_addr <  `AIPD_IX_PARAM_FN0 + 16'h0008)
        begin
          dec_fn = 1'b1;
          dec_ch = req_addr[2:0] - 3'd2;
        end
      end
      2'd2:
      begin
        if (!req_write && req_addr == `AIPD_IX_DIAG_SUB
            && req_sub >= `AIPD_SX_FIRST && req_sub <= `AIPD_SX_LAST
            && req_sub != 8'h12)
        begin
          // one field per subindex; 13h holds the four timestamp bytes
          dec_diag  = 1'b1; // [R13]
          dec_start = (req_sub == `AIPD_SX_LAST) ? 5'd16
                    : req_sub[4:0] - 5'd2;
          dec_len   = (req_sub == `AIPD_SX_LAST) ? 5'd4 : 5'd1;
        end
        else if (req_write && req_addr == `AIPD_IX_PARAM_SUB
                 && req_sub == `AIPD_SX_MAINS_REJECTION_SELECT)
          dec_mains_rejection_select = 1'b1;
        else if (req_write && req_addr == `AIPD_IX_PARAM_SUB
                 && req_sub >= `AIPD_SX_FN0 && req_sub < `AIPD_SX_FN0 + 8'h08)
        begin
          dec_fn = 1'b1;
          dec_ch = req_sub[2:0] - 3'd2;
        end
      end
      default:
        dec_len = 5'd0;
    endcase
  end

  // error flags collect live per-channel state; any change outside the fourth diag byte stamps the ticker
  wire [7:0] a_nxt = {(|sup_bad), 2'b00, stat_aux_missing, (|cany),
                      stat_ext, stat_int, stat_fail}; // [R15]
  // link faults sit in the fourth diag byte only and leave the stamp alone
  wire [7:0] d_nxt = {3'b000, stat_comm_err, 4'h0};
  wire       diag_change = (a_nxt != module_diag_flags_r)
                        || (cany != channel_error_summary_r)
                        || (cerr != channel_error_detail_r);

  integer i;
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mains_rejection_select_r <= `AIPD_MAINS_REJECTION_SELECT_RST;
      channel_range_select_r   <= {NCH{`AIPD_FN_RST}}; // [R19]
      module_diag_flags_r      <= 8'h00;
      secondary_diag_flags_r   <= 8'h00;
      channel_error_summary_r  <= 8'h00;
      channel_error_detail_r   <= {NCH*8{1'b0}};
      diag_event_timestamp_r   <= 32'h0000_0000;
      usec_r                   <= 32'h0000_0000;
      div_r                    <= 6'h00;
      state_r                  <= ST_IDLE;
      rd_byte_r                <= 5'h00;
      rd_len_r                 <= 5'h00;
      rd_bad_r                 <= 1'b0;
      rsp_valid                <= 1'b0;
      rsp_rdata                <= 8'h00;
      rsp_err                  <= 1'b0;
      rsp_last                 <= 1'b0;
      chan_value               <= {NCH*16{1'b0}};
      interference_rejection   <= {NCH*2{1'b0}};
      chan_enable              <= {NCH{1'b1}};
      chan_err_led             <= {NCH{1'b0}};
      mod_err_led              <= 1'b0;
    end
    else if (clk_en)
    begin
      // ticker wraps naturally at 2^32
      if (div_r == TICK_DIV - 6'd1)
      begin
        div_r  <= 6'h00;
        usec_r <= usec_r + 32'h0000_0001; // [R18]
      end
      else
        div_r <= div_r + 6'd1;

      // flags track the live causes and clear once a cause is gone
      module_diag_flags_r     <= a_nxt;
      secondary_diag_flags_r  <= d_nxt;
      channel_error_summary_r <= cany; // [R17]
      channel_error_detail_r  <= cerr; // [R16]
      if (diag_change)
        diag_event_timestamp_r <= usec_r; // [R18]

      // indicators only; no interrupt line exists [R10]
      chan_err_led <= cany; // [R9]
      mod_err_led  <= |a_nxt;

      for (i = 0; i < NCH; i = i + 1)
      begin
        // pins follow the stored setup one edge after a write
        chan_enable[i] <= channel_range_select_r[i*8 +: 8] != `AIPD_FN_OFF; // [R3]
        interference_rejection[i*2 +: 2] <= mains_rejection_select_r[i*2 +: 2]; // [R1]
      end

      // values move only on the strobe, so a read sees one sample set
      if (sample_stb)
        chan_value <= cvalue; // [R20]

      // answer strobes clear each cycle unless set again, so rsp_valid stays high through a read burst; all hold while the clock enable is low
      rsp_valid <= 1'b0;
      rsp_last  <= 1'b0;
      rsp_err   <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (req_valid && req_write)
          begin
            rsp_valid <= 1'b1;
            rsp_last  <= 1'b1;
            // unknown write target is refused with the error flag
            rsp_err   <= !(dec_mains_rejection_select || dec_fn);
            if (dec_mains_rejection_select && req_byte == 5'd0)
              mains_rejection_select_r[7:0] <= req_wdata; // [R1]
            if (dec_mains_rejection_select && req_byte == 5'd1)
              mains_rejection_select_r[15:8] <= req_wdata;
            if (dec_fn)
              channel_range_select_r[dec_ch*8 +: 8] <= req_wdata;
            state_r <= ST_WR;
          end
          else if (req_valid)
          begin
            rd_byte_r <= dec_start;
            rd_len_r  <= dec_len;
            rd_bad_r  <= !dec_diag;
            state_r   <= ST_RD;
          end
        end

        ST_RD:
        begin
          // one byte per cycle; unknown target answers one error byte
          rsp_valid <= 1'b1;
          rsp_err   <= rd_bad_r;
          rsp_rdata <= rd_bad_r ? 8'h00 : diag_byte(rd_byte_r);
          rd_byte_r <= rd_byte_r + 5'd1;
          // length counts down; the byte seen at count one is the last
          rd_len_r  <= rd_len_r - 5'd1;
          if (rd_bad_r || rd_len_r == 5'd1)
          begin
            rsp_last <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end

        // dead cycle keeps a write answer apart from the next request
        ST_WR:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // aipd_bank

// file: hw/aipd_chan.v
// one channel: range scaling, clamping and error bits
// assumes a signed 12-bit conversion sample with full scale at 10 V
`timescale 1ns/100ps
`include "aipd_regs.vh"
module aipd_chan
(
  // setup
  input  wire [7:0]  fn_num,
  // sample
  input  wire [11:0] raw,
  // result
  output reg  [15:0] value,
  output reg  [7:0]  err
);
  reg signed [31:0] scaled;
  reg signed [31:0] hi;
  reg signed [31:0] lo;
  reg               known;
  reg               bip;
  always @*
  begin
    known = 1'b1;
    bip   = (fn_num == `AIPD_FN_BIP_DEC) || (fn_num == `AIPD_FN_BIP_P2);
    // raw full scale 2047 is 10 V; decimal and power-of-two nominal
    case (fn_num)
      `AIPD_FN_BIP_DEC, `AIPD_FN_UNI_DEC:
      begin
        scaled = ($signed({{20{raw[11]}}, raw}) * 27648) / 2047; // [R4]
        hi     = $signed({16'h0000, `AIPD_DEC_MAX});
        lo     = bip ? $signed({16'hFFFF, `AIPD_DEC_MIN})
                     : $signed({16'hFFFF, `AIPD_UDEC_MIN}); // [R6] [R8]
      end
      `AIPD_FN_BIP_P2, `AIPD_FN_UNI_P2:
      begin
        scaled = ($signed({{20{raw[11]}}, raw}) * 16384) / 2047; // [R5]
        hi     = $signed({16'h0000, `AIPD_P2_MAX});
        lo     = bip ? $signed({16'hFFFF, `AIPD_P2_MIN})
                     : $signed({16'hFFFF, `AIPD_UP2_MIN}); // [R7] [R8]
      end
      default:
      begin
        known  = 1'b0;
        scaled = 32'sd0;
        hi     = 32'sd0;
        lo     = 32'sd0;
      end
    endcase
    err   = 8'h00;
    value = 16'h0000;
    if (fn_num == `AIPD_FN_OFF)
      value = 16'h0000; // [R3]
    else if (!known)
      err[`AIPD_C_CFG] = 1'b1; // [R16]
    else if (scaled > hi)
    begin
      value             = hi[15:0]; // [R20]
      err[`AIPD_C_OVER] = 1'b1; // [R16]
    end
    else if (scaled < lo)
    begin
      value              = lo[15:0]; // [R20]
      err[`AIPD_C_UNDER] = 1'b1; // [R16]
    end
    else
      value = scaled[15:0];
  end
endmodule // aipd_chan

// file: hw/aipd_regs.vh
// constants for the analog input parameter and diagnostic bank
// assumes a byte-wide record port driven by the backplane coupler
`ifndef AIPD_REGS_VH
`define AIPD_REGS_VH
// record set numbers
`define AIPD_REC_DIAG_SHORT   8'h00
`define AIPD_REC_DIAG_FULL    8'h01
`define AIPD_REC_PARAM_MAINS_REJECTION_SELECT   8'h01
`define AIPD_REC_PARAM_FN0    8'h80
// object indices
`define AIPD_IX_DIAG_SHORT    16'h2F00
`define AIPD_IX_DIAG_FULL     16'h2F01
`define AIPD_IX_DIAG_SUB      16'h5005
`define AIPD_IX_PARAM_SUPR0   16'h3100
`define AIPD_IX_PARAM_SUPR1   16'h3101
`define AIPD_IX_PARAM_FN0     16'h3102
`define AIPD_IX_PARAM_SUB     16'h3100
// subindex range of the diagnostic fields and the parameter subindices
`define AIPD_SX_FIRST         8'h02
`define AIPD_SX_LAST          8'h13
`define AIPD_SX_MAINS_REJECTION_SELECT          8'h01
`define AIPD_SX_FN0           8'h02
// record lengths in bytes
`define AIPD_DIAG_LEN         5'd20
`define AIPD_DIAG_SHORT_LEN   5'd4
// constant description bytes and reset values
`define AIPD_MODCLASS         8'h15
`define AIPD_CHKIND           8'h71
`define AIPD_DIAG_BITS_PER_CHANNEL           8'h08
`define AIPD_CHANNEL_COUNT            8'h08
`define AIPD_MAINS_REJECTION_SELECT_RST         16'h0000
`define AIPD_FN_RST           8'h12
// function numbers
`define AIPD_FN_BIP_DEC       8'h12
`define AIPD_FN_BIP_P2        8'h22
`define AIPD_FN_UNI_DEC       8'h10
`define AIPD_FN_UNI_P2        8'h20
`define AIPD_FN_OFF           8'hFF
// nominal values and limits
`define AIPD_DEC_NOM          16'h6C00
`define AIPD_P2_NOM           16'h4000
`define AIPD_DEC_MAX          16'h7EFF
`define AIPD_DEC_MIN          16'h8100
`define AIPD_P2_MAX           16'h5000
`define AIPD_P2_MIN           16'hB000
`define AIPD_UDEC_MIN         16'hED00
`define AIPD_UP2_MIN          16'hF333
// suppression codes
`define AIPD_SUP_OFF          2'b00
`define AIPD_SUP_60HZ         2'b01
`define AIPD_SUP_50HZ         2'b10
// diag bit positions
`define AIPD_A_FAIL           0
`define AIPD_A_INT            1
`define AIPD_A_EXT            2
`define AIPD_A_CHAN           3
`define AIPD_A_AUX            4
`define AIPD_A_PARM           7
`define AIPD_C_CFG            0
`define AIPD_C_UNDER          6
`define AIPD_C_OVER           7
// ticker
`define AIPD_CLK_MHZ          6'h28
`define AIPD_TICK_US          6'h01
`endif
